//--- rcr_pkg.sv
package rcr_pkg;

   // Register location in the special-function-register space
   localparam logic [7:0] RCR_SFR_PAGE = 8'h00;
   localparam logic [7:0] RCR_SFR_ADDR = 8'hEF;

   // Bit positions of reset_cause_and_enable
   localparam int RCR_BIT_CALENDAR = 7;
   localparam int RCR_BIT_FLASH    = 6;
   localparam int RCR_BIT_CMP      = 5;
   localparam int RCR_BIT_SOFT     = 4;
   localparam int RCR_BIT_WDT      = 3;
   localparam int RCR_BIT_CLK_LOSS = 2;
   localparam int RCR_BIT_POWER    = 1;
   localparam int RCR_BIT_PIN      = 0;

   // Values after power-on
   localparam logic [7:0] RCR_FLAGS_POR   = 8'h02;
   localparam logic       RCR_SUPPLY_EN_R = 1'b1;

   // Timing at 100 MHz
   localparam int RCR_CLK_PERIOD_NS   = 10;
   localparam int RCR_CLOCK_LOSS_US   = 100;
   localparam int RCR_CLOCK_LOSS_CYC  = (RCR_CLOCK_LOSS_US * 1000) / RCR_CLK_PERIOD_NS;
   localparam int RCR_HOLD_CYC        = 16;
   localparam int RCR_CNT_W           = 16;

   // Reset requests and the low-power mode level as seen by the cause logic, one cycle each or levels
   typedef struct packed {
      logic calendar_alarm;
      logic calendar_osc_fail;
      logic flash_fault;
      logic comparator_trip;
      logic watchdog_overflow;
      logic supply_low;
      logic low_power_mode;
   } rcr_sources_s;

   // Register-port access
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] page;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rcr_sfr_req_s;

   typedef enum logic {
      RCR_RUN,
      RCR_HOLD
   } rcr_state_e;

endpackage

//--- rcr_clock_loss_detector.sv
`timescale 1ns/1ps
module rcr_clock_loss_detector #(
   parameter int LOSS_CYCLES = rcr_pkg::RCR_CLOCK_LOSS_CYC
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic reset_n,
   // Monitored clock level and control
   input  wire logic sys_clk_level,
   input  wire logic armed,
   // Timeout level, held until the monitored clock toggles or the detector is disarmed
   output logic      timeout
);

   logic                          last_level_reg;
   logic [rcr_pkg::RCR_CNT_W-1:0] stuck_count_reg;

   localparam logic [rcr_pkg::RCR_CNT_W-1:0] LIMIT = rcr_pkg::RCR_CNT_W'(LOSS_CYCLES - 1);

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         last_level_reg <= 1'b0;
      end else begin
         last_level_reg <= sys_clk_level;
      end
   end

   // Any edge of the monitored clock restarts the one-shot
   always_ff @(posedge ref_clk) begin
      if (!reset_n || !armed || (sys_clk_level != last_level_reg)) begin
         stuck_count_reg <= '0;
         timeout         <= 1'b0;
      end else if (stuck_count_reg == LIMIT) begin
         timeout <= 1'b1;
      end else begin
         stuck_count_reg <= stuck_count_reg + 1'b1;
         timeout         <= 1'b0;
      end
   end

endmodule

//--- rcr_top.sv
// Contract
// - Bit 7 write enables calendar alarm and oscillator-fail reset sources.
// - Bit 7 reads 1 when a calendar event caused the last reset.
// - Bit 6 is read-only, 1 after a flash fault reset.
// - Bit 5 write enables the comparator as reset source.
// - Bit 5 reads 1 when the comparator caused the last reset.
// - Writing 1 to bit 4 forces a full system reset; 0 does nothing.
// - Bit 4 reads 1 after a software-forced reset.
// - Bit 3 is read-only, 1 after a watchdog overflow reset.
// - Bit 2 write enables clock-loss detector; reads 1 after its reset.
// - Bit 1 write enables the supply monitor as reset source.
// - Bit 1 reads 1 after power-on or supply-monitor reset.
// - Bit 0 is read-only, 1 after an external pin reset.
// - Register sits at page 0x0, address 0xEF, eight bits wide.
// - Clock loss resets when the system clock sticks over 100 us.
// - Clock-loss and watchdog sources gated off in low power, then restored.
`timescale 1ns/1ps
module rcr_top #(
   parameter int CLOCK_LOSS_CYCLES = rcr_pkg::RCR_CLOCK_LOSS_CYC
) (
   // Clock and power-on reset
   input  wire logic                  ref_clk,
   input  wire logic                  reset_n,
   // Register port
   input  wire rcr_pkg::rcr_sfr_req_s sfr_req,
   output logic [7:0]                 sfr_rdata,
   // Reset sources
   input  wire rcr_pkg::rcr_sources_s sources,
   input  wire logic                  pin_reset_n,
   input  wire logic                  sys_clk_level,
   // System reset and state
   output logic                       system_reset,
   output logic                       clock_loss_armed
);

   logic [7:0]          flags_reg;
   logic [7:0]          flags_next;
   logic                calendar_en_reg;
   logic                cmp_en_reg;
   logic                clock_loss_en_reg;
   logic                supply_en_reg;
   logic                soft_req_reg;
   logic                clock_loss_timeout;
   logic                hit;
   logic                req_any;
   logic                hold_src;
   logic [4:0]          hold_count_reg;
   rcr_pkg::rcr_state_e state_reg;

   localparam logic [4:0] HOLD_LAST = 5'(rcr_pkg::RCR_HOLD_CYC - 1);

   assign hit = (sfr_req.page == rcr_pkg::RCR_SFR_PAGE) &&
                (sfr_req.addr == rcr_pkg::RCR_SFR_ADDR);

   rcr_clock_loss_detector #(
      .LOSS_CYCLES (CLOCK_LOSS_CYCLES)
   ) u_clock_loss_detector (
      .ref_clk       (ref_clk),
      .reset_n       (reset_n),
      .sys_clk_level (sys_clk_level),
      .armed         (clock_loss_armed),
      .timeout       (clock_loss_timeout)
   );

   // Decide the cause of a new reset; only one flag is set, highest priority wins
   always_comb begin
      flags_next = '0;
      if (!pin_reset_n) begin
         flags_next[rcr_pkg::RCR_BIT_PIN] = 1'b1;
      end else if (supply_en_reg && sources.supply_low) begin
         flags_next[rcr_pkg::RCR_BIT_POWER] = 1'b1;
      end else if (clock_loss_timeout) begin
         flags_next[rcr_pkg::RCR_BIT_CLK_LOSS] = 1'b1;
      end else if (sources.watchdog_overflow && !sources.low_power_mode) begin
         flags_next[rcr_pkg::RCR_BIT_WDT] = 1'b1;
      end else if (sources.flash_fault) begin
         flags_next[rcr_pkg::RCR_BIT_FLASH] = 1'b1;
      end else if (soft_req_reg) begin
         flags_next[rcr_pkg::RCR_BIT_SOFT] = 1'b1;
      end else if (cmp_en_reg && sources.comparator_trip) begin
         flags_next[rcr_pkg::RCR_BIT_CMP] = 1'b1;
      end else if (calendar_en_reg &&
                   (sources.calendar_alarm || sources.calendar_osc_fail)) begin
         flags_next[rcr_pkg::RCR_BIT_CALENDAR] = 1'b1;
      end
   end

   assign req_any  = |flags_next;
   // Pin and supply-low levels keep the system in reset while they persist; the comparator term lapses once the hold clears cmp_en_reg
   assign hold_src = !pin_reset_n || (supply_en_reg && sources.supply_low) ||
                     (cmp_en_reg && sources.comparator_trip);

   // Reset sequencing
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state_reg      <= rcr_pkg::RCR_HOLD;
         hold_count_reg <= '0;
         system_reset   <= 1'b1;
      end else begin
         unique case (state_reg)
            rcr_pkg::RCR_RUN: begin
               if (req_any) begin
                  state_reg      <= rcr_pkg::RCR_HOLD;
                  hold_count_reg <= '0;
                  system_reset   <= 1'b1;
               end
            end
            rcr_pkg::RCR_HOLD: begin
               if (hold_src) begin
                  hold_count_reg <= '0;
               end else if (hold_count_reg == HOLD_LAST) begin
                  state_reg    <= rcr_pkg::RCR_RUN;
                  system_reset <= 1'b0;
               end else begin
                  hold_count_reg <= hold_count_reg + 1'b1;
               end
            end
         endcase
      end
   end

   // Cause flags are captured once, on entry to a reset
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         flags_reg <= rcr_pkg::RCR_FLAGS_POR;
      end else if (state_reg == rcr_pkg::RCR_RUN && req_any) begin
         flags_reg <= flags_next;
      end
   end

   // Software reset request; writing 0 leaves it alone
   always_ff @(posedge ref_clk) begin
      if (!reset_n || state_reg == rcr_pkg::RCR_HOLD) begin
         soft_req_reg <= 1'b0;
      end else if (sfr_req.wr && hit && sfr_req.wdata[rcr_pkg::RCR_BIT_SOFT]) begin
         soft_req_reg <= 1'b1;
      end
   end

   // Enables are write-only; every system reset returns them to defaults
   always_ff @(posedge ref_clk) begin
      if (!reset_n || state_reg == rcr_pkg::RCR_HOLD) begin
         calendar_en_reg   <= 1'b0;
         cmp_en_reg        <= 1'b0;
         clock_loss_en_reg <= 1'b0;
         supply_en_reg     <= rcr_pkg::RCR_SUPPLY_EN_R;
      end else if (sfr_req.wr && hit) begin
         calendar_en_reg   <= sfr_req.wdata[rcr_pkg::RCR_BIT_CALENDAR];
         cmp_en_reg        <= sfr_req.wdata[rcr_pkg::RCR_BIT_CMP];
         clock_loss_en_reg <= sfr_req.wdata[rcr_pkg::RCR_BIT_CLK_LOSS];
         supply_en_reg     <= sfr_req.wdata[rcr_pkg::RCR_BIT_POWER];
      end
   end

   // Gating leaves the enable untouched, so exit from low power restores it
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         clock_loss_armed <= 1'b0;
      end else begin
         clock_loss_armed <= clock_loss_en_reg && !sources.low_power_mode &&
                             state_reg == rcr_pkg::RCR_RUN;
      end
   end

   // Reads return the cause flags, one cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         sfr_rdata <= '0;
      end else if (sfr_req.rd && hit && !system_reset) begin
         sfr_rdata <= flags_reg;
      end else begin
         sfr_rdata <= '0;
      end
   end

endmodule

//--- rcr_assertions.sv
`timescale 1ns/1ps
module rcr_assertions #(
   parameter int CLOCK_LOSS_CYCLES = 20
) (
   // Clock and reset
   input wire logic                  ref_clk,
   input wire logic                  reset_n,
   // Register port
   input wire rcr_pkg::rcr_sfr_req_s sfr_req,
   input wire logic [7:0]            sfr_rdata,
   // Sources
   input wire rcr_pkg::rcr_sources_s sources,
   input wire logic                  pin_reset_n,
   input wire logic                  sys_clk_level,
   // Outputs
   input wire logic                  system_reset,
   input wire logic                  clock_loss_armed
);
   logic hit;
   logic quiet;
   assign hit = sfr_req.page == rcr_pkg::RCR_SFR_PAGE && sfr_req.addr == rcr_pkg::RCR_SFR_ADDR;
   assign quiet = !system_reset && pin_reset_n;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   a_miss_reads_zero: assert property (!(sfr_req.rd && hit && !system_reset) |=> !sfr_rdata)
      else $error("read data without a read hit");
   a_single_flag: assert property (sfr_rdata != 8'h00 |-> $onehot(sfr_rdata))
      else $error("more than one cause flag");
   a_wdog_resets: assert property (!system_reset && sources == 7'h04 |=> system_reset)
      else $error("watchdog did not reset");
   a_pin_resets: assert property (!pin_reset_n |=> system_reset)
      else $error("pin did not reset");
   a_soft_resets: assert property (sfr_req.wr && hit && sfr_req.wdata[4] && !system_reset
      |-> ##2 system_reset)
      else $error("software reset not taken");
   a_hold_length: assert property ($fell(system_reset) |-> $past(system_reset, 16))
      else $error("reset hold too short");
   a_armed_cleared: assert property ($rose(system_reset) |=> !clock_loss_armed)
      else $error("detector still armed after reset");
   a_armed_set: assert property (quiet && hit && sources == '0 && $rose(sfr_req.wr)
      && sfr_req.wdata[2] && !sfr_req.wdata[4] |-> ##[1:2] clock_loss_armed)
      else $error("detector not armed");
   a_sleep_gates: assert property (quiet && sources == 7'h05 |=> !system_reset)
      else $error("watchdog reset in low power");
endmodule

bind rcr_top rcr_assertions #(.CLOCK_LOSS_CYCLES(CLOCK_LOSS_CYCLES)) chk_u (
   .ref_clk(ref_clk), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
   .sources(sources), .pin_reset_n(pin_reset_n), .sys_clk_level(sys_clk_level),
   .system_reset(system_reset), .clock_loss_armed(clock_loss_armed));

//--- rcr_tb.sv
`timescale 1ns/1ps
module testbench;
   localparam int LOSS = 20;
   logic                  ref_clk = 1'b0;
   logic                  reset_n = 1'b0;
   rcr_pkg::rcr_sfr_req_s req = '0;
   rcr_pkg::rcr_sources_s src = '0;
   logic                  pin_n = 1'b1;
   logic                  lvl = 1'b0;
   logic                  fz = 1'b0;
   logic [7:0]            rdata;
   logic                  sys_rst;
   logic [7:0]            prev = 8'h02;
   int                    err_count = 0;
   int                    total_checks = 0;
   int                    seed = 84592;
   rcr_top #(.CLOCK_LOSS_CYCLES(LOSS)) dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
      .sfr_req(req), .sfr_rdata(rdata), .sources(src), .pin_reset_n(pin_n),
      .sys_clk_level(lvl), .system_reset(sys_rst), .clock_loss_armed());
   always #5 ref_clk = ~ref_clk;
   // Random toggling keeps the detector quiet unless a case freezes the level
   always @(negedge ref_clk) if (!fz) lvl <= $random(seed);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      req <= '{w, !w, p, a, d};
      @(negedge ref_clk);
      req <= '0;
   endtask
   task automatic rd(input logic [7:0] p, input logic [7:0] a, input logic [7:0] exp);
      // Read data stands for one cycle only, so compare at the negedge right after it lands
      acc(1'b0, p, a, 8'h00);
      chk(rdata, exp);
   endtask
   task automatic settle(input int n);
      int i;
      for (i = 0; i < n && sys_rst !== 1'b1; i++) @(negedge ref_clk);
      src <= '0;
      pin_n <= 1'b1;
      fz <= 1'b0;
      for (i = 0; i < 80 && sys_rst !== 1'b0; i++) @(negedge ref_clk);
      chk({7'h00, sys_rst}, 8'h00);
   endtask
   // Clock loss needs LOSS cycles, so any other cause wins first
   function automatic logic [7:0] expect_flags(input logic [6:0] s, input logic p,
         input logic [7:0] en, input logic f, input logic [7:0] old);
      if (!p) return 8'h01;
      if (s[1] && en[1]) return 8'h02;
      if (s[2] && !s[0]) return 8'h08;
      if (s[4]) return 8'h40;
      if (s[3] && en[5]) return 8'h20;
      if ((s[6] || s[5]) && en[7]) return 8'h80;
      if (en[2] && f && !s[0]) return 8'h04;
      return old;
   endfunction
   task automatic run_case(input logic [6:0] s, input logic p, input logic [7:0] en, input logic f);
      logic [7:0] exp;
      exp = expect_flags(s, p, en, f, prev);
      acc(1'b1, 8'h00, 8'hEF, en | 8'h49);
      @(negedge ref_clk);
      src <= s;
      pin_n <= p;
      fz <= f;
      settle(3 * LOSS);
      rd(8'h00, 8'hEF, exp);
      prev = exp;
      $display("case %h %b %h %b done", s, p, en, f);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #400000;
      err_count++;
      finish_test;
   end
   initial begin
      repeat (16) @(negedge ref_clk);
      reset_n <= 1'b1;
      settle(0);
      rd(8'h00, 8'hEF, 8'h02);
      rd(8'h01, 8'hEF, 8'h00);
      rd(8'h00, 8'($random(seed)) & 8'hEE, 8'h00);
      run_case(7'h04, 1'b1, 8'h02, 1'b0);
      run_case(7'h10, 1'b1, 8'h02, 1'b0);
      run_case(7'h00, 1'b0, 8'h02, 1'b0);
      run_case(7'h08, 1'b1, 8'h22, 1'b0);
      run_case(7'h08, 1'b1, 8'h02, 1'b0);
      run_case(7'h40, 1'b1, 8'h82, 1'b0);
      run_case(7'h20, 1'b1, 8'h82, 1'b0);
      run_case(7'h02, 1'b1, 8'h02, 1'b0);
      run_case(7'h06, 1'b1, 8'h00, 1'b0);
      run_case(7'h05, 1'b1, 8'h06, 1'b1);
      run_case(7'h00, 1'b1, 8'h06, 1'b1);
      run_case(7'h04, 1'b0, 8'h02, 1'b0);
      acc(1'b1, 8'h00, 8'hEF, 8'h10);
      settle(4);
      rd(8'h00, 8'hEF, 8'h10);
      acc(1'b1, 8'h00, 8'hEF, 8'hEF);
      settle(6);
      rd(8'h00, 8'hEF, 8'h10);
      prev = 8'h10;
      repeat (12) begin
         run_case(7'($random(seed)), 1'($random(seed)), 8'($random(seed)) & 8'hA6,
            1'($random(seed)));
      end
      finish_test;
   end
endmodule
